//--- rtl/adc_ctrl_pkg.sv
// Package with register offsets, field positions and reset values of the converter control block.
`default_nettype none
package adc_ctrl_pkg;
   localparam logic [3:0] OFS_RESULT_LOW   = 4'h0;
   localparam logic [3:0] OFS_RESULT_HIGH  = 4'h1;
   localparam logic [3:0] OFS_LOWER_LOW    = 4'h2;
   localparam logic [3:0] OFS_LOWER_HIGH   = 4'h3;
   localparam logic [3:0] OFS_UPPER_LOW    = 4'h4;
   localparam logic [3:0] OFS_UPPER_HIGH   = 4'h5;
   localparam logic [3:0] OFS_CTRL_MAIN    = 4'h6;
   localparam logic [3:0] OFS_SRC_CLK      = 4'h7;
   localparam logic [3:0] OFS_GAIN_REF     = 4'h8;
   localparam logic [3:0] OFS_TRIG_LIMIT   = 4'h9;
   localparam logic [3:0] OFS_START_DELAY  = 4'hA;
   localparam logic [3:0] OFS_BANDGAP      = 4'hB;
   localparam logic [3:0] OFS_LIMIT_STATUS = 4'hC;
   // Control main fields.
   localparam int BIT_START   = 7;
   localparam int BIT_BUSY    = 6;
   localparam int BIT_ENABLE  = 5;
   localparam int BIT_JUSTIFY = 4;
   // Trigger and limit control fields.
   localparam int BIT_PWM_TRIG_SEL  = 7;
   localparam int BIT_DELAY_SEL     = 6;
   localparam int BIT_UPPER_ENABLE  = 4;
   localparam int BIT_LOWER_ENABLE  = 3;
   localparam logic [7:0] SRC_CLK_MASK   = 8'hE7;
   localparam logic [7:0] GAIN_REF_MASK  = 8'h9F;
   localparam logic [7:0] TRIG_MASK      = 8'hFB;
   localparam logic [7:0] RESET_BYTE     = 8'h00;
   localparam logic [11:0] RESET_WORD    = 12'h000;
   localparam logic [11:0] UPPER_RESET   = 12'hFFF;
   localparam logic [2:0] SRC_EXTERNAL   = 3'h0;
   localparam logic [3:0] CHAN_LAST      = 4'h8;
   localparam logic [3:0] CHAN_NONE      = 4'hF;
   localparam logic [7:0] CONV_CYCLES    = 8'h10;
endpackage
`default_nettype wire

//--- rtl/adc_result_and_boundary_control.sv
// Converter control: register file, start sequencing, result storage and limit check.
//
// Functional notes
// - Each completed conversion yields an unsigned twelve-bit result.
// - Source kind plus channel field select input.
// - Internal sources include amplifier, supply, reference, ground.
// - Result compared to upper and lower limits.
// - PWM-triggered start may wait a delay.
// - Delay length comes from eight-bit register.
// - One bit enables bandgap reference output.
// - Result byte pair is read only.
// - Justify bit selects left or right alignment.
// - Unused result bit positions read zero.
// - Result unchanged while converter disabled.
// - Limit pairs aligned like the result.
// - New result readable after conversion finishes.
// - Busy flag set on launch, cleared on completion.
// - Internal source disconnects the external channel.
//
// Decided for this implementation: the strobed register port and the address map.
`default_nettype none
module adc_result_and_boundary_control (
   input  wire logic        sys_clk,         // 20 MHz system clock.
   input  wire logic        rst_n,           // Synchronous reset, active low.
   input  wire logic [3:0]  reg_addr,        // Register address.
   input  wire logic [7:0]  reg_wdata,       // Write data.
   input  wire logic        reg_wr,          // Write strobe.
   input  wire logic        reg_rd,          // Read strobe.
   output logic      [7:0]  reg_rdata,       // Read data, one cycle after the strobe.
   input  wire logic        pwm_trigger,     // Asynchronous PWM start request.
   input  wire logic [11:0] sample_data,     // Converter core output word.
   output logic      [2:0]  source_kind_select,      // Selected source kind.
   output logic      [3:0]  external_channel_select, // Connected pin, 4'hF when none.
   output logic             sample_en,       // Converter core sampling/converting.
   output logic             converter_enable,        // Analog power enable.
   output logic             bandgap_output_enable,   // Bandgap reference output enable.
   output logic             limit_event      // One-cycle pulse when limit condition met.
);
   logic [7:0]  ctrl_reg;
   logic [7:0]  src_clk_reg;
   logic [7:0]  gain_ref_reg;
   logic [7:0]  trig_reg;
   logic [7:0]  start_delay_length;
   logic        bandgap_reg;
   logic [11:0] result_reg;
   logic [11:0] lower_reg;
   logic [11:0] upper_reg;
   logic        busy_reg;
   logic [1:0]  hit_reg;
   logic        check_reg;
   logic [7:0]  delay_cnt;
   logic [7:0]  conv_cnt;
   logic [1:0]  trig_sync;
   logic        trig_prev;
   logic        tick;
   logic        justify;
   logic        enabled;
   logic        sw_start;
   logic        hw_start;
   logic [7:0]  res_low_b;
   logic [7:0]  res_high_b;
   logic [7:0]  low_low_b;
   logic [7:0]  low_high_b;
   logic [7:0]  up_low_b;
   logic [7:0]  up_high_b;

   typedef enum logic [1:0] {IDLE, DELAY, CONVERT, STORE} conv_state_t;
   conv_state_t state;

   assign justify = ctrl_reg[adc_ctrl_pkg::BIT_JUSTIFY];
   assign enabled = ctrl_reg[adc_ctrl_pkg::BIT_ENABLE];

   function automatic logic [7:0] pack_high(input logic [11:0] v, input logic j);
      pack_high = j ? {4'h0, v[11:8]} : v[11:4];
   endfunction

   function automatic logic [7:0] pack_low(input logic [11:0] v, input logic j);
      pack_low = j ? v[7:0] : {v[3:0], 4'h0};
   endfunction

   // Result pair presented in the selected alignment, spare bits zero.
   assign res_high_b = pack_high(result_reg, justify);
   assign res_low_b  = pack_low(result_reg, justify);
   assign up_high_b  = pack_high(upper_reg, justify);
   assign up_low_b   = pack_low(upper_reg, justify);
   assign low_high_b = pack_high(lower_reg, justify);
   assign low_low_b  = pack_low(lower_reg, justify);

   // Software start on the falling edge of the start bit.
   assign sw_start = reg_wr && (reg_addr == adc_ctrl_pkg::OFS_CTRL_MAIN) && ctrl_reg[adc_ctrl_pkg::BIT_START]
                     && !reg_wdata[adc_ctrl_pkg::BIT_START];
   assign hw_start = trig_reg[adc_ctrl_pkg::BIT_PWM_TRIG_SEL] && trig_sync[1] && !trig_prev;

   // Trigger pin synchroniser.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         trig_sync <= 2'b00;
         trig_prev <= 1'b0;
      end else begin
         trig_sync <= {trig_sync[0], pwm_trigger};
         trig_prev <= trig_sync[1];
      end
   end

   clk_prescaler #(.WIDTH(7)) u_prescaler (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .run     (enabled),
      .div_sel (src_clk_reg[2:0]),
      .tick    (tick)
   );

   // Control register writes; the busy bit is hardware-owned.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_reg           <= adc_ctrl_pkg::RESET_BYTE;
         src_clk_reg        <= adc_ctrl_pkg::RESET_BYTE;
         gain_ref_reg       <= adc_ctrl_pkg::RESET_BYTE;
         trig_reg           <= adc_ctrl_pkg::RESET_BYTE;
         start_delay_length <= adc_ctrl_pkg::RESET_BYTE;
         bandgap_reg        <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            adc_ctrl_pkg::OFS_CTRL_MAIN:   ctrl_reg <= reg_wdata & 8'hBF;
            adc_ctrl_pkg::OFS_SRC_CLK:     src_clk_reg <= reg_wdata & adc_ctrl_pkg::SRC_CLK_MASK;
            adc_ctrl_pkg::OFS_GAIN_REF:    gain_ref_reg <= reg_wdata & adc_ctrl_pkg::GAIN_REF_MASK;
            adc_ctrl_pkg::OFS_TRIG_LIMIT:  trig_reg <= reg_wdata & adc_ctrl_pkg::TRIG_MASK;
            adc_ctrl_pkg::OFS_START_DELAY: start_delay_length <= reg_wdata;
            adc_ctrl_pkg::OFS_BANDGAP:     bandgap_reg <= reg_wdata[0];
            default: ;
         endcase
      end
   end

   // Limit registers, stored as twelve-bit words; byte writes are placed by the current alignment.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lower_reg <= adc_ctrl_pkg::RESET_WORD;
         upper_reg <= adc_ctrl_pkg::UPPER_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            adc_ctrl_pkg::OFS_LOWER_LOW:
               lower_reg <= justify ? {lower_reg[11:8], reg_wdata} : {lower_reg[11:4], reg_wdata[7:4]};
            adc_ctrl_pkg::OFS_LOWER_HIGH:
               lower_reg <= justify ? {reg_wdata[3:0], lower_reg[7:0]} : {reg_wdata, lower_reg[3:0]};
            adc_ctrl_pkg::OFS_UPPER_LOW:
               upper_reg <= justify ? {upper_reg[11:8], reg_wdata} : {upper_reg[11:4], reg_wdata[7:4]};
            adc_ctrl_pkg::OFS_UPPER_HIGH:
               upper_reg <= justify ? {reg_wdata[3:0], upper_reg[7:0]} : {reg_wdata, upper_reg[3:0]};
            default: ;
         endcase
      end
   end

   // Conversion sequencer.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state     <= IDLE;
         busy_reg  <= 1'b0;
         delay_cnt <= adc_ctrl_pkg::RESET_BYTE;
         conv_cnt  <= adc_ctrl_pkg::RESET_BYTE;
         result_reg <= adc_ctrl_pkg::RESET_WORD;
         check_reg <= 1'b0;
      end else begin
         check_reg <= 1'b0;
         case (state)
            IDLE: begin
               if (enabled && (sw_start || hw_start)) begin
                  busy_reg <= 1'b1;
                  conv_cnt <= adc_ctrl_pkg::CONV_CYCLES;
                  if (hw_start && trig_reg[adc_ctrl_pkg::BIT_DELAY_SEL] && (start_delay_length != 8'h00)) begin
                     delay_cnt <= start_delay_length;
                     state     <= DELAY;
                  end else begin
                     state <= CONVERT;
                  end
               end
            end
            DELAY: begin
               if (!enabled) begin
                  state    <= IDLE;
                  busy_reg <= 1'b0;
               end else if (tick) begin
                  delay_cnt <= delay_cnt - 8'h01;
                  if (delay_cnt == 8'h01) begin
                     state <= CONVERT;
                  end
               end
            end
            CONVERT: begin
               if (!enabled) begin
                  state    <= IDLE;
                  busy_reg <= 1'b0;
               end else if (tick) begin
                  conv_cnt <= conv_cnt - 8'h01;
                  if (conv_cnt == 8'h01) begin
                     state <= STORE;
                  end
               end
            end
            STORE: begin
               result_reg <= sample_data;
               busy_reg   <= 1'b0;
               check_reg  <= 1'b1;
               state      <= IDLE;
            end
            default: state <= IDLE;
         endcase
      end
   end

   // Limit comparison one cycle after the result is stored.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hit_reg     <= 2'b00;
         limit_event <= 1'b0;
      end else begin
         limit_event <= 1'b0;
         if (check_reg) begin
            hit_reg <= {result_reg > upper_reg, result_reg < lower_reg};
            limit_event <= (trig_reg[adc_ctrl_pkg::BIT_UPPER_ENABLE] && (result_reg > upper_reg))
                        || (trig_reg[adc_ctrl_pkg::BIT_LOWER_ENABLE] && (result_reg < lower_reg));
         end
      end
   end

   // Analog routing outputs.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         source_kind_select      <= adc_ctrl_pkg::SRC_EXTERNAL;
         external_channel_select <= adc_ctrl_pkg::CHAN_NONE;
         sample_en               <= 1'b0;
         converter_enable        <= 1'b0;
         bandgap_output_enable   <= 1'b0;
      end else begin
         source_kind_select <= src_clk_reg[7:5];
         if (src_clk_reg[7:5] != adc_ctrl_pkg::SRC_EXTERNAL || ctrl_reg[3:0] > adc_ctrl_pkg::CHAN_LAST) begin
            external_channel_select <= adc_ctrl_pkg::CHAN_NONE;
         end else begin
            external_channel_select <= ctrl_reg[3:0];
         end
         sample_en             <= (state == CONVERT);
         converter_enable      <= enabled;
         bandgap_output_enable <= bandgap_reg;
      end
   end

   // Read port; result registers have no write path.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= adc_ctrl_pkg::RESET_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            adc_ctrl_pkg::OFS_RESULT_LOW:   reg_rdata <= res_low_b;
            adc_ctrl_pkg::OFS_RESULT_HIGH:  reg_rdata <= res_high_b;
            adc_ctrl_pkg::OFS_LOWER_LOW:    reg_rdata <= low_low_b;
            adc_ctrl_pkg::OFS_LOWER_HIGH:   reg_rdata <= low_high_b;
            adc_ctrl_pkg::OFS_UPPER_LOW:    reg_rdata <= up_low_b;
            adc_ctrl_pkg::OFS_UPPER_HIGH:   reg_rdata <= up_high_b;
            adc_ctrl_pkg::OFS_CTRL_MAIN:    reg_rdata <= {ctrl_reg[7], busy_reg, ctrl_reg[5:0]};
            adc_ctrl_pkg::OFS_SRC_CLK:      reg_rdata <= src_clk_reg;
            adc_ctrl_pkg::OFS_GAIN_REF:     reg_rdata <= gain_ref_reg;
            adc_ctrl_pkg::OFS_TRIG_LIMIT:   reg_rdata <= trig_reg;
            adc_ctrl_pkg::OFS_START_DELAY:  reg_rdata <= start_delay_length;
            adc_ctrl_pkg::OFS_BANDGAP:      reg_rdata <= {7'h00, bandgap_reg};
            adc_ctrl_pkg::OFS_LIMIT_STATUS: reg_rdata <= {6'h00, hit_reg};
            default:                        reg_rdata <= adc_ctrl_pkg::RESET_BYTE;
         endcase
      end else begin
         reg_rdata <= adc_ctrl_pkg::RESET_BYTE;
      end
   end
endmodule
`default_nettype wire

//--- rtl/clk_prescaler.sv
// Programmable power-of-two divider giving a one-cycle converter clock enable.
`default_nettype none
module clk_prescaler #(
   parameter int WIDTH = 7
) (
   input  wire logic       sys_clk, // System clock.
   input  wire logic       rst_n,   // Synchronous reset, active low.
   input  wire logic       run,     // Counting allowed.
   input  wire logic [2:0] div_sel, // Divide by two to the power of this.
   output logic            tick     // One-cycle enable pulse.
);
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] mask;

   assign mask = WIDTH'((1 << div_sel) - 1);

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !run) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else begin
         tick    <= ((cnt_reg & mask) == mask);
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- verif/adc_ctrl_checker_assertions.sv
// Port-level assertions for the converter control block.
`default_nettype none
module adc_ctrl_checker (
   input wire logic       sys_clk,                 // System clock.
   input wire logic       rst_n,                   // Reset, active low.
   input wire logic [3:0] reg_addr,                // Register address.
   input wire logic [7:0] reg_wdata,               // Write data.
   input wire logic       reg_wr,                  // Write strobe.
   input wire logic       reg_rd,                  // Read strobe.
   input wire logic [7:0] reg_rdata,               // Read data.
   input wire logic [2:0] source_kind_select,      // Source kind.
   input wire logic [3:0] external_channel_select, // Connected pin.
   input wire logic       sample_en,               // Converting.
   input wire logic       converter_enable,        // Analog power.
   input wire logic       bandgap_output_enable,   // Bandgap output.
   input wire logic       limit_event              // Limit pulse.
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read slot");
   chk_event_pulse: assert property (limit_event |=> !limit_event)
      else $error("limit pulse longer than one cycle");
   chk_internal_disc: assert property (source_kind_select != 3'h0 |-> external_channel_select == 4'hF)
      else $error("pin connected while internal source chosen");
   chk_channel_range: assert property (external_channel_select <= 4'h8 || external_channel_select == 4'hF)
      else $error("pin select out of range");
   chk_sample_off: assert property (!converter_enable |=> !sample_en)
      else $error("sampling while converter disabled");
   // Outputs copy a register that is itself written at the strobe edge, so they follow two edges later.
   chk_bandgap_write: assert property (reg_wr && reg_addr == adc_ctrl_pkg::OFS_BANDGAP |-> ##2
      bandgap_output_enable == $past(reg_wdata[0], 2)) else $error("bandgap enable does not follow write");
   chk_enable_write: assert property (reg_wr && reg_addr == adc_ctrl_pkg::OFS_CTRL_MAIN |-> ##2
      converter_enable == $past(reg_wdata[adc_ctrl_pkg::BIT_ENABLE], 2)) else $error("enable does not follow write");
   chk_source_write: assert property (reg_wr && reg_addr == adc_ctrl_pkg::OFS_SRC_CLK |-> ##2
      source_kind_select == $past(reg_wdata[7:5], 2)) else $error("source kind does not follow write");
   chk_source_hold: assert property (!(reg_wr && reg_addr == adc_ctrl_pkg::OFS_SRC_CLK) |-> ##2
      $stable(source_kind_select)) else $error("source kind changed without write");
endmodule
bind adc_result_and_boundary_control adc_ctrl_checker adc_ctrl_checker_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .source_kind_select, .external_channel_select, .sample_en, .converter_enable,
   .bandgap_output_enable, .limit_event);
`default_nettype wire

//--- verif/analog_sources.sv
// Far-side model: analog levels presented to the converter core for each input selection.
`default_nettype none
module analog_sources (
   input  wire logic        sys_clk,                 // System clock.
   input  wire logic [2:0]  source_kind_select,      // Source kind.
   input  wire logic [3:0]  external_channel_select, // Connected pin.
   input  wire logic [11:0] levels [0:15],           // Pins at 0 to 8, internal kinds at 9 to 13.
   output logic      [11:0] sample_data              // Converted word.
);
   logic [11:0] float_q = 12'hA5C;
   // A floating input wanders every cycle so a wrong selection cannot match by chance.
   always @(posedge sys_clk) float_q <= ~float_q + 12'h001;
   always_comb begin
      if (source_kind_select == 3'h0) begin
         sample_data = external_channel_select <= 4'h8 ? levels[external_channel_select] : float_q;
      end else if (source_kind_select >= 3'h6) begin
         sample_data = 12'h000;
      end else begin
         sample_data = levels[{1'b1, source_kind_select}];
      end
   end
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the converter control block.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, rst_n, reg_wr, reg_rd, pwm_trigger, sample_en, last_j;
   logic        converter_enable, bandgap_output_enable, limit_event;
   logic [3:0]  reg_addr, external_channel_select;
   logic [7:0]  reg_wdata, reg_rdata, d;
   logic [2:0]  source_kind_select;
   logic [11:0] sample_data, last_r;
   logic [15:0] w;
   logic [11:0] levels [0:15];
   int          bad_count, cmp_count, ev_count, lat0, lat6;
   logic [3:0]  ta [8] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
   logic [7:0]  te [8] = '{8'h00, 8'h00, 8'hE7, 8'h9F, 8'hFB, 8'hFF, 8'h01, 8'h00};
   adc_result_and_boundary_control adc_result_and_boundary_control_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .pwm_trigger, .sample_data, .source_kind_select, .external_channel_select,
      .sample_en, .converter_enable, .bandgap_output_enable, .limit_event);
   analog_sources analog_sources_i (.sys_clk, .source_kind_select, .external_channel_select, .levels, .sample_data);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      if (limit_event === 1'b1) ev_count++;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      v = reg_rdata;
   endtask
   function automatic logic [15:0] fmt(input logic [11:0] v, input logic j);
      return j ? {4'h0, v} : {v, 4'h0};
   endfunction
   task automatic poll_idle;
      d = 8'h40;
      for (int i = 0; i < 100 && d[6] !== 1'b0; i++) rd(4'h6, d);
      check(d[6], 1'b0, "busy never cleared");
      if (d[6] !== 1'b0) give_verdict;
   endtask
   task automatic conv(input logic [2:0] kind, input logic [3:0] ch, input logic j, input logic [11:0] lo, up,
                       input logic [1:0] en, input logic b);
      logic [11:0] r;
      logic [15:0] f;
      int n;
      r = kind == 3'h0 ? levels[ch] : (kind >= 3'h6 ? 12'h000 : levels[{1'b1, kind}]);
      if (b) begin
         lo = r;
         up = r;
      end
      wr(4'h7, {kind, 3'b000, kind[1:0]});
      wr(4'h6, {3'b001, j, ch});
      wr(4'h9, {3'b000, en, 3'b000});
      f = fmt(lo, j);
      wr(4'h2, f[7:0]);
      wr(4'h3, f[15:8]);
      f = fmt(up, j);
      wr(4'h4, f[7:0]);
      wr(4'h5, f[15:8]);
      n = ev_count;
      wr(4'h6, {3'b101, j, ch});
      wr(4'h6, {3'b001, j, ch});
      rd(4'h6, d);
      check(d[6], 1'b1, "busy after launch");
      check(16'(converter_enable), 16'h0001, "converter power");
      check(16'({source_kind_select, external_channel_select}), 16'({kind, kind ? 4'hF : ch}), "routing");
      poll_idle;
      repeat (4) @(posedge sys_clk);
      check(16'(ev_count - n), 16'((en[1] && r > up) || (en[0] && r < lo)), "limit events");
      rd(4'hC, d);
      check(d, {6'h00, r > up, r < lo}, "limit status");
      rd(4'h1, f[15:8]);
      rd(4'h0, f[7:0]);
      check(f, fmt(r, j), "result pair");
      wr(4'h6, {3'b001, ~j, ch});
      rd(4'h1, f[15:8]);
      rd(4'h0, f[7:0]);
      check(f, fmt(r, ~j), "result other format");
      rd(4'h3, f[15:8]);
      rd(4'h2, f[7:0]);
      check(f, fmt(lo, ~j), "lower limit other format");
      last_r = r;
      last_j = ~j;
   endtask
   task automatic pwm_lat(input logic [7:0] dl, output int lat);
      wr(4'hA, dl);
      wr(4'h9, 8'hC0);
      @(posedge sys_clk);
      pwm_trigger <= 1'b1;
      lat = 0;
      @(negedge sys_clk);
      while (sample_en !== 1'b1 && lat < 300) begin
         @(negedge sys_clk);
         lat++;
      end
      check(16'(lat >= 300), 16'h0000, "no sampling after trigger");
      if (lat >= 300) give_verdict;
      poll_idle;
      @(posedge sys_clk);
      pwm_trigger <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   initial begin
      #5000000;
      check(16'h0001, 16'h0000, "run time limit");
      give_verdict;
   end
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      pwm_trigger = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      ev_count = 0;
      void'($urandom(93));
      for (int k = 0; k < 16; k++) levels[k] = 12'($urandom);
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 14; a++) begin
         rd(4'(a), d);
         check(d, a == 5 ? 8'hFF : (a == 4 ? 8'hF0 : 8'h00), "reset value");
      end
      $display("test reset values done");
      for (int k = 0; k < 8; k++) begin
         wr(ta[k], 8'hFF);
         rd(ta[k], d);
         check(d, te[k], "write mask");
         if (ta[k] == 4'hB) check(16'(bandgap_output_enable), 16'h0001, "bandgap on");
      end
      wr(4'h6, 8'h40);
      rd(4'h6, d);
      check(d, 8'h00, "busy not writable");
      wr(4'hB, 8'h00);
      rd(4'hB, d);
      check(16'(bandgap_output_enable), 16'h0000, "bandgap off");
      $display("test access kinds done");
      for (int k = 0; k < 24; k++) begin
         conv(k < 9 ? 3'h0 : (k < 16 ? 3'(k - 8) : 3'($urandom % 8)), k < 9 ? 4'(k) : 4'($urandom % 9), k[0],
              12'($urandom), 12'($urandom), 2'($urandom), k % 3 == 0);
      end
      $display("test conversions done");
      wr(4'h7, 8'h00);
      wr(4'h6, {3'b101, last_j, 4'h0});
      wr(4'h6, {3'b001, last_j, 4'h0});
      wr(4'h6, {3'b000, last_j, 4'h0});
      wr(4'h6, {3'b100, last_j, 4'h0});
      wr(4'h6, {3'b000, last_j, 4'h0});
      repeat (40) @(posedge sys_clk);
      rd(4'h6, d);
      check(d, {3'b000, last_j, 4'h0}, "disabled control");
      check(16'(converter_enable), 16'h0000, "converter power off");
      rd(4'h1, w[15:8]);
      rd(4'h0, w[7:0]);
      check(w, fmt(last_r, last_j), "result kept");
      $display("test disabled converter done");
      wr(4'h6, 8'h0B);
      rd(4'h6, d);
      check(16'(external_channel_select), 16'h000F, "no pin for reserved channel");
      wr(4'h6, 8'h20);
      pwm_lat(8'h00, lat0);
      pwm_lat(8'h06, lat6);
      check(16'(lat6 - lat0), 16'h0006, "start delay");
      rd(4'h1, w[15:8]);
      rd(4'h0, w[7:0]);
      check(w, fmt(levels[0], 1'b0), "triggered result");
      $display("test triggered start done");
      give_verdict;
   end
endmodule
`default_nettype wire
